// File: hw/adc_cal_consts.vh
/*
  Shared constants of the calibration and conversion control block:
  register addresses, field positions, reset values, timing counts.
  Assumes it is included by bare name from the hw/ design files.
*/
`ifndef ADC_CAL_CONSTS_VH
`define ADC_CAL_CONSTS_VH

// Register addresses on the serial link
`define REG_RESULT    4'h0
`define REG_STATE     4'h1
`define REG_THIRD_CFG 4'h3
`define REG_SCAN      4'h7
`define REG_INTERVAL  4'h8
`define REG_OFFSET    4'h9
`define REG_GAIN      4'ha
`define REG_STATUS    4'hd

// Field positions in third_configuration
`define CFG_GAIN_EN   0
`define CFG_OFF_EN    1
`define CFG_STYLE_HI  7
`define CFG_STYLE_LO  6

// Converter state field codes
`define ST_SHUTDOWN   2'b00
`define ST_STANDBY    2'b10
`define ST_CONVERT    2'b11

// Reset values
`define GAIN_RESET    24'h800000
`define OFFSET_RESET  24'h000000
`define THIRD_CFG_RESET 8'h00
`define SCAN_RESET    16'h0000
`define INTERVAL_RST  24'h000000

// Timing counts in decimation clock periods
`define STARTUP_PERIODS 9'h100
`define GAIN_LATENCY    5'h17

// Output range limits
`define FULL_POS      24'h7fffff
`define FULL_NEG      24'h800000

`endif

// File: hw/spi_link.v
/*
  Serial register link slave, mode 0,0: command byte then 24 data bits,
  MSB first. Assumes cs_n, sck and mosi come from outside the clock
  domain and sck is much slower than ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.vh"

module spi_link (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        cs_n,
  input  wire        sck,
  input  wire        mosi,
  input  wire [23:0] rd_word,
  input  wire        rd_load,
  output reg         miso_q,
  output reg         miso_oe_q,
  output reg         cmd_q,
  output reg  [7:0]  cmd_byte_q,
  output reg         wr_q,
  output reg  [23:0] wr_data_q
);

  reg        cs_m;
  reg        cs_s;
  reg        sck_m;
  reg        sck_s;
  reg        sck_p;
  reg        mosi_m;
  reg        mosi_s;
  reg [5:0]  bit_cnt_q;
  reg        data_on_q;
  reg [23:0] in_sh_q;
  reg [23:0] out_sh_q;

  wire rise = sck_s & ~sck_p;
  wire fall = ~sck_s & sck_p;

  always @(posedge ref_clk) begin
    if (rst) begin
      cs_m      <= 1'b1;
      cs_s      <= 1'b1;
      sck_m     <= 1'b0;
      sck_s     <= 1'b0;
      sck_p     <= 1'b0;
      mosi_m    <= 1'b0;
      mosi_s    <= 1'b0;
      bit_cnt_q <= 6'h00;
      data_on_q <= 1'b0;
      in_sh_q   <= 24'h000000;
      out_sh_q  <= 24'h000000;
      cmd_q     <= 1'b0;
      cmd_byte_q <= 8'h00;
      wr_q      <= 1'b0;
      wr_data_q <= 24'h000000;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      cs_m   <= cs_n;
      cs_s   <= cs_m;
      sck_m  <= sck;
      sck_s  <= sck_m;
      sck_p  <= sck_s;
      mosi_m <= mosi;
      mosi_s <= mosi_m;
      cmd_q  <= 1'b0;
      wr_q   <= 1'b0;
      if (cs_s) begin
        bit_cnt_q <= 6'h00;
        data_on_q <= 1'b0;
      end else if (rise && bit_cnt_q != 6'h20) begin
        in_sh_q   <= {in_sh_q[22:0], mosi_s};
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == 6'h07) begin
          cmd_q      <= 1'b1;
          cmd_byte_q <= {in_sh_q[6:0], mosi_s};
        end
        if (bit_cnt_q >= 6'h08)
          data_on_q <= 1'b1;
        if (bit_cnt_q == 6'h1f) begin
          wr_q      <= cmd_byte_q[3];
          wr_data_q <= {in_sh_q[22:0], mosi_s};
        end
      end
      // Shift out only after the first data bit has been sampled
      if (rd_load)
        out_sh_q <= rd_word;
      else if (fall && data_on_q && !cs_s)
        out_sh_q <= {out_sh_q[22:0], 1'b0};
      miso_q    <= out_sh_q[23];
      miso_oe_q <= ~cs_s;
    end
  end

endmodule // spi_link
`default_nettype wire

// File: hw/gain_shift_add.v
/*
  Add-and-shift gain multiplier: signed sum times unsigned gain / 2^23.
  Assumes start only while idle and one step per decimation period.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.vh"

module gain_shift_add (
  input  wire               ref_clk,
  input  wire               rst,
  input  wire               start,
  input  wire signed [24:0] sum_in,
  input  wire [23:0]        gain_in,
  output reg                busy_q,
  output wire               done,
  output wire signed [26:0] prod
);

  reg signed [25:0] acc_q;
  reg signed [24:0] sum_q;
  reg [23:0]        gain_q;
  reg [4:0]         step_q;

  wire signed [25:0] term = gain_q[step_q] ? {sum_q[24], sum_q} : 26'sh0;
  wire signed [25:0] acc_d = (acc_q + term) >>> 1;
  wire signed [26:0] msb_term =
    gain_q[23] ? {{2{sum_q[24]}}, sum_q} : 27'sh0;

  assign done = busy_q && (step_q == `GAIN_LATENCY - 5'h01);
  assign prod = {acc_d[25], acc_d} + msb_term;

  always @(posedge ref_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      acc_q  <= 26'sh0;
      sum_q  <= 25'sh0;
      gain_q <= 24'h000000;
      step_q <= 5'h00;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      acc_q  <= 26'sh0;
      sum_q  <= sum_in;
      gain_q <= gain_in;
      step_q <= 5'h00;
    end else if (busy_q) begin
      acc_q  <= acc_d;
      step_q <= step_q + 5'h01;
      if (done)
        busy_q <= 1'b0;
    end
  end

endmodule // gain_shift_add
`default_nettype wire

// File: hw/adc_cal_core.v
/*
  Offset/gain correction and conversion style control of a delta-sigma
  converter, with its registers behind a serial link. Assumes ref_clk
  is the decimation clock and raw_code is valid from the decimator in
  the last cycle of each conversion.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.vh"

module adc_cal_core #(
  parameter [15:0] CONV_CYCLES = 16'h0040
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        cs_n,
  input  wire        sck,
  input  wire        mosi,
  input  wire [23:0] raw_code,
  output wire        miso_q,
  output wire        miso_oe_q,
  output reg         data_ready_q,
  output reg         overload_q,
  output reg         conv_start_q,
  output reg  [3:0]  channel_q,
  output reg  [1:0]  converter_state_q
);

  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_CONV = 2'b01;
  localparam [1:0] S_GAP  = 2'b10;

  localparam [15:0] CONV_LAST = CONV_CYCLES - 16'h0001;

  reg [7:0]  third_cfg_q;
  reg [15:0] scan_q;
  reg [23:0] interval_q;
  reg [23:0] offset_q;
  reg [23:0] gain_q;
  reg [23:0] result_q;
  reg        pending_q;
  reg [8:0]  startup_q;
  reg [1:0]  fsm_q;
  reg [15:0] conv_cnt_q;
  reg [23:0] gap_q;
  reg [23:0] rd_word_q;
  reg        rd_load_q;
  reg [23:0] rd_mux;

  wire        cmd_p;
  wire [7:0]  cmd_byte;
  wire        wr_p;
  wire [23:0] wr_data;
  wire        gain_busy;
  wire        gain_done;
  wire signed [26:0] gain_prod;

  wire [3:0] acc_addr = cmd_byte[7:4];
  wire       off_en   = third_cfg_q[`CFG_OFF_EN];
  wire       gain_en  = third_cfg_q[`CFG_GAIN_EN];
  wire [1:0] style    = third_cfg_q[`CFG_STYLE_HI:`CFG_STYLE_LO];
  wire       scan_mode = |scan_q;

  // Returns {found, index} of highest set mask bit below the limit
  function [4:0] next_chan;
    input [15:0] mask;
    input [4:0]  below;
    reg   [4:0]  k;
    begin
      next_chan = 5'h00;
      for (k = 5'h00; k < 5'h10; k = k + 5'h01) begin
        if (mask[k[3:0]] && ({1'b0, k[3:0]} < below))
          next_chan = {1'b1, k[3:0]};
      end
    end
  endfunction

  // Clamps a wide signed value to the 24-bit range, MSB is overload
  function [24:0] saturate;
    input [26:0] v;
    begin
      if (!v[26] && (|v[25:23]))
        saturate = {1'b1, `FULL_POS};
      else if (v[26] && !(&v[25:23]))
        saturate = {1'b1, `FULL_NEG};
      else
        saturate = {1'b0, v[23:0]};
    end
  endfunction

  wire [4:0] first_ch = next_chan(scan_q, 5'h10);
  wire [4:0] next_ch  = next_chan(scan_q, {1'b0, channel_q});

  // Last cycle of a running conversion: the raw code is taken now
  wire sample = (fsm_q == S_CONV) &&
                (converter_state_q == `ST_CONVERT) &&
                (conv_cnt_q == 16'h0000);

  wire signed [24:0] raw_s = {raw_code[23], raw_code};
  wire signed [24:0] off_s = off_en ? {offset_q[23], offset_q} : 25'sh0;
  wire signed [24:0] sum   = raw_s + off_s;
  // guard bits kept for the final check
  wire signed [26:0] sum_w = {{2{sum[24]}}, sum};

  // gain is started only when enabled
  wire gain_start = sample && gain_en;

  wire rd_cmd    = cmd_p && !cmd_byte[3];
  wire rd_result = rd_cmd && (acc_addr == `REG_RESULT);

  spi_link u_link (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .cs_n       (cs_n),
    .sck        (sck),
    .mosi       (mosi),
    .rd_word    (rd_word_q),
    .rd_load    (rd_load_q),
    .miso_q     (miso_q),
    .miso_oe_q  (miso_oe_q),
    .cmd_q      (cmd_p),
    .cmd_byte_q (cmd_byte),
    .wr_q       (wr_p),
    .wr_data_q  (wr_data)
  );

  // gain code is unsigned, scaled by 2^-23
  // 23-cycle add-and-shift on the decimation clock
  gain_shift_add u_gain (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (gain_start),
    .sum_in  (sum),
    .gain_in (gain_q),
    .busy_q  (gain_busy),
    .done    (gain_done),
    .prod    (gain_prod)
  );

  // Configuration registers written over the link
  always @(posedge ref_clk) begin
    if (rst) begin
      third_cfg_q <= `THIRD_CFG_RESET;
      scan_q     <= `SCAN_RESET;
      interval_q <= `INTERVAL_RST;
      offset_q   <= `OFFSET_RESET;
      gain_q     <= `GAIN_RESET;
    end else if (wr_p) begin
      case (acc_addr)
        `REG_THIRD_CFG: third_cfg_q <= wr_data[7:0];
        `REG_SCAN:     scan_q     <= wr_data[15:0];
        `REG_INTERVAL: interval_q <= wr_data;
        `REG_OFFSET:   offset_q   <= wr_data;
        `REG_GAIN:     gain_q     <= wr_data;
        default:       third_cfg_q <= third_cfg_q;
      endcase
    end
  end

  // Read data for the link
  always @* begin
    rd_mux = 24'h000000;
    case (acc_addr)
      `REG_RESULT:   rd_mux = result_q;
      `REG_STATE:    rd_mux = {22'h000000, converter_state_q};
      `REG_THIRD_CFG: rd_mux = {16'h0000, third_cfg_q};
      `REG_SCAN:     rd_mux = {8'h00, scan_q};
      `REG_INTERVAL: rd_mux = interval_q;
      `REG_OFFSET:   rd_mux = offset_q;
      `REG_GAIN:     rd_mux = gain_q;
      `REG_STATUS:   rd_mux = {20'h00000, gain_busy,
                               fsm_q != S_IDLE, overload_q, pending_q};
      default:       rd_mux = 24'h000000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rd_word_q <= 24'h000000;
      rd_load_q <= 1'b0;
    end else begin
      rd_load_q <= rd_cmd;
      if (rd_cmd)
        rd_word_q <= rd_mux;
    end
  end

  // startup timer held at 256 in shutdown, counts otherwise
  always @(posedge ref_clk) begin
    if (rst)
      startup_q <= `STARTUP_PERIODS;
    else if (!converter_state_q[1])
      startup_q <= `STARTUP_PERIODS;
    else if (startup_q != 9'h000)
      startup_q <= startup_q - 9'h001;
  end

  // Conversion sequencer and converter state field
  always @(posedge ref_clk) begin
    if (rst) begin
      fsm_q             <= S_IDLE;
      conv_cnt_q        <= 16'h0000;
      gap_q             <= 24'h000000;
      channel_q         <= 4'h0;
      conv_start_q      <= 1'b0;
      converter_state_q <= `ST_SHUTDOWN;
    end else begin
      conv_start_q <= 1'b0;
      case (fsm_q)
        S_IDLE: begin
          if (converter_state_q == `ST_CONVERT &&
              startup_q == 9'h000) begin
            fsm_q        <= S_CONV;
            conv_cnt_q   <= CONV_LAST;
            channel_q    <= scan_mode ? first_ch[3:0] : 4'h0;
            conv_start_q <= 1'b1;
          end
        end
        S_CONV: begin
          if (converter_state_q != `ST_CONVERT)
            fsm_q <= S_IDLE;
          else if (conv_cnt_q != 16'h0000)
            conv_cnt_q <= conv_cnt_q - 16'h0001;
          else if (scan_mode && next_ch[4]) begin
            channel_q    <= next_ch[3:0];
            conv_cnt_q   <= CONV_LAST;
            conv_start_q <= 1'b1;
          end else begin
            case (style)
              `ST_CONVERT: begin
                if (scan_mode) begin
                  fsm_q <= S_GAP;
                  gap_q <= interval_q;
                end else begin
                  conv_cnt_q   <= CONV_LAST;
                  conv_start_q <= 1'b1;
                end
              end
              `ST_STANDBY: begin
                converter_state_q <= `ST_STANDBY;
                fsm_q             <= S_IDLE;
              end
              default: begin
                converter_state_q <= `ST_SHUTDOWN;
                fsm_q             <= S_IDLE;
              end
            endcase
          end
        end
        S_GAP: begin
          if (converter_state_q != `ST_CONVERT)
            fsm_q <= S_IDLE;
          else if (gap_q != 24'h000000)
            gap_q <= gap_q - 24'h000001;
          else begin
            fsm_q        <= S_CONV;
            conv_cnt_q   <= CONV_LAST;
            channel_q    <= first_ch[3:0];
            conv_start_q <= 1'b1;
          end
        end
        default: fsm_q <= S_IDLE;
      endcase
      // A link write of the state field overrides the sequencer
      if (wr_p && acc_addr == `REG_STATE)
        converter_state_q <= wr_data[1:0];
    end
  end

  // Result register, data ready and overload
  // settings sampled only as the raw code is taken
  always @(posedge ref_clk) begin
    if (rst) begin
      result_q     <= 24'h000000;
      overload_q   <= 1'b0;
      data_ready_q <= 1'b0;
      pending_q    <= 1'b0;
    end else begin
      data_ready_q <= 1'b0;
      if (gain_done) begin
        // ready comes 24 cycles after the sample
        // clamp and flag the final value
        {overload_q, result_q} <= saturate(gain_prod);
        data_ready_q           <= 1'b1;
      end else if (sample && !gain_en) begin
        // gain skipped, check the final value only
        {overload_q, result_q} <= saturate(sum_w);
        data_ready_q           <= 1'b1;
      end
      // New result wins over a read clearing the flag
      pending_q <= gain_done | (sample & ~gain_en) |
                   (pending_q & ~rd_result);
    end
  end

endmodule // adc_cal_core
`default_nettype wire

// File: dv/adc_cal_checker_assertions.sv
/*
  Port checker for adc_cal_core, attached to every instance by bind.
  Assumes one clock, ref_clk, and a synchronous active-high rst.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_consts.vh"

module adc_cal_checker #(
  parameter [15:0] CONV_CYCLES = 16'h0040
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        mosi,
  input wire logic [23:0] raw_code,
  input wire logic        miso_q,
  input wire logic        miso_oe_q,
  input wire logic        data_ready_q,
  input wire logic        overload_q,
  input wire logic        conv_start_q,
  input wire logic [3:0]  channel_q,
  input wire logic [1:0]  converter_state_q
);
  // Start pulse stands in the first of CONV_CYCLES conversion cycles
  localparam int DR_OFF  = CONV_CYCLES;
  localparam int DR_GAIN = CONV_CYCLES + 23;
  localparam [15:0] GAP_MIN = CONV_CYCLES - 16'h0001;
  logic [9:0]  warm_q;
  logic [15:0] gap_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Cycles out of shutdown, and cycles since the last start
  always @(posedge ref_clk) begin
    warm_q <= (rst || !converter_state_q[1]) ? 10'h000 :
              warm_q + {9'h000, warm_q != 10'h3ff};
    gap_q  <= (rst || conv_start_q) ? 16'h0000 :
              gap_q + {15'h0000, gap_q != 16'hffff};
  end

  a_ready_latency: assert property (
    data_ready_q |-> $past(conv_start_q, DR_OFF) ||
                     $past(conv_start_q, DR_GAIN))
    else $error("data ready at wrong distance from start");
  a_ready_pulse: assert property (
    data_ready_q |=> !data_ready_q)
    else $error("data ready longer than one cycle");
  a_start_pulse: assert property (
    conv_start_q |=> !conv_start_q)
    else $error("start longer than one cycle");
  a_start_state: assert property (
    conv_start_q |-> converter_state_q == `ST_CONVERT)
    else $error("start outside converting state");
  a_start_warm: assert property (
    conv_start_q |-> warm_q >= 10'h100)
    else $error("start before startup time elapsed");
  a_no_overlap: assert property (
    conv_start_q |-> gap_q >= GAP_MIN)
    else $error("start inside a running conversion");
  a_ovl_hold: assert property (
    !data_ready_q |-> $stable(overload_q))
    else $error("overload moved without a result");
  a_oe_release: assert property (
    cs_n [*5] |-> !miso_oe_q)
    else $error("miso driven while deselected");
  a_oe_drive: assert property (
    (!cs_n) [*5] |-> miso_oe_q)
    else $error("miso not driven while selected");

  c_gain_path: cover property (data_ready_q && $past(conv_start_q, DR_GAIN));
  c_clamp: cover property (data_ready_q && overload_q);
  c_back_to_back: cover property (conv_start_q ##DR_OFF conv_start_q);
endmodule // adc_cal_checker

bind adc_cal_core adc_cal_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi),
  .raw_code(raw_code), .miso_q(miso_q), .miso_oe_q(miso_oe_q),
  .data_ready_q(data_ready_q), .overload_q(overload_q),
  .conv_start_q(conv_start_q), .channel_q(channel_q),
  .converter_state_q(converter_state_q)
);
`default_nettype wire

// File: dv/spi_host.sv
/*
  Serial host model: mode 0,0 frames of a command byte and 24 data bits.
  Assumes the device syncs the link to its own clock; sck period 80 ns.
*/
`timescale 1ns/100ps
`default_nettype none

module spi_host (
  output logic      cs_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end

  task automatic xfer(input logic [3:0] addr, input logic wr,
                      input logic [23:0] wdata, output logic [23:0] rdata);
    logic [31:0] frame;
    frame = {addr, wr, 3'h0, wdata};
    rdata = 24'h000000;
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = frame[i];
      #40 sck = 1'b1;
      // Sample late in the high phase: miso trails sck by the sync delay
      #39 if (i < 24) rdata[i] = miso;
      #1 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released data line shows the inverse of its last bit
    mosi = ~mosi;
    #100;
  endtask
endmodule // spi_host
`default_nettype wire

// File: dv/tb_top.sv
/*
  Testbench for adc_cal_core: register frames through spi_host, raw codes
  driven after the rising edge, results read back and compared.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam [15:0] CONV = 16'h0020;
  logic             ref_clk;
  logic             rst;
  logic [23:0]      raw_code;
  logic [23:0]      rdata;
  logic [23:0]      n;
  int               num_errors;
  int               n_tests;
  int               cycles;
  wire logic        cs_n, sck, mosi, miso_q, miso_oe_q;
  wire logic        data_ready_q, overload_q, conv_start_q;
  wire logic [3:0]  channel_q;
  wire logic [1:0]  converter_state_q;

  adc_cal_core #(.CONV_CYCLES(CONV)) DUT (
    .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .raw_code(raw_code), .miso_q(miso_q), .miso_oe_q(miso_oe_q),
    .data_ready_q(data_ready_q), .overload_q(overload_q),
    .conv_start_q(conv_start_q), .channel_q(channel_q),
    .converter_state_q(converter_state_q)
  );
  spi_host host (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso_q));

  always #5 ref_clk = ~ref_clk;

  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    host.xfer(a, 1'b1, d, rdata);
  endtask

  task automatic rd(input logic [3:0] a);
    host.xfer(a, 1'b0, 24'h000000, rdata);
  endtask

  task automatic wait_dr(output logic [23:0] cnt);
    cnt = 24'h000000;
    do begin
      @(negedge ref_clk);
      cnt = cnt + 24'h000001;
    end while (data_ready_q !== 1'b1 && cnt < 24'h0007d0);
    if (data_ready_q !== 1'b1) begin
      chk("data_ready", 24'h000001, 24'h000000);
    end
  endtask

  // One conversion started by the state field, then result read back
  task automatic run(input logic [23:0] raw, input logic [23:0] exp,
                     input logic ovl, input logic [1:0] st);
    logic [23:0] cnt;
    @(posedge ref_clk);
    #1 raw_code = raw;
    wr(4'h1, 24'h000003);
    wait_dr(cnt);
    rd(4'h0);
    chk("result", exp, rdata);
    chk("overload", {23'h000000, ovl}, {23'h000000, overload_q});
    chk("state", {22'h000000, st}, {22'h000000, converter_state_q});
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    raw_code = 24'h000000;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (6) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(4'ha);
    chk("gain reset", 24'h800000, rdata);
    rd(4'h9);
    chk("offset reset", 24'h000000, rdata);
    wr(4'h0, 24'h123456);
    rd(4'h0);
    chk("result read-only", 24'h000000, rdata);
    rd(4'hf);
    chk("unmapped", 24'h000000, rdata);
    wr(4'h9, 24'h000010);
    wr(4'ha, 24'h400000);
    wr(4'h3, 24'h000080);
    run(24'h000100, 24'h000100, 1'b0, 2'b10);
    wr(4'h9, 24'hffff00);
    wr(4'h3, 24'h000082);
    rd(4'h0);
    chk("result kept", 24'h000100, rdata);
    run(24'h000100, 24'h000000, 1'b0, 2'b10);
    wr(4'h9, 24'h000005);
    rd(4'h0);
    chk("result kept", 24'h000000, rdata);
    run(24'h000100, 24'h000105, 1'b0, 2'b10);
    wr(4'h9, 24'h000100);
    wr(4'h3, 24'h000083);
    rd(4'h0);
    chk("result kept", 24'h000105, rdata);
    run(24'h7fffff, 24'h40007f, 1'b0, 2'b10);
    wr(4'ha, 24'hffffff);
    rd(4'h0);
    chk("result kept", 24'h40007f, rdata);
    run(24'h7fffff, 24'h7fffff, 1'b1, 2'b10);
    wr(4'h9, 24'hffffff);
    run(24'h800000, 24'h800000, 1'b1, 2'b10);
    wr(4'ha, 24'h000000);
    run(24'h7fffff, 24'h000000, 1'b0, 2'b10);
    wr(4'h3, 24'h000000);
    run(24'h000123, 24'h000123, 1'b0, 2'b00);
    wr(4'h9, 24'h000000);
    wr(4'ha, 24'h800000);
    wr(4'h3, 24'h0000c3);
    run(24'h000042, 24'h000042, 1'b0, 2'b11);
    wait_dr(n);
    wait_dr(n);
    chk("period", {8'h00, CONV}, n);
    chk("state", 24'h000003, {22'h000000, converter_state_q});
    wr(4'h1, 24'h000000);
    // Two-channel sequence, one pass, ends on the lowest channel
    wr(4'h7, 24'h000003);
    wr(4'h3, 24'h000080);
    run(24'h000042, 24'h000042, 1'b0, 2'b10);
    chk("channel", 24'h000000, {20'h00000, channel_q});
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
